// [logic/cda_pkg.sv]
// Package of constants for the charger detect and accessory control block
// What this block does
// [R1] UART entry loads regulator level from power setting
// [R2] UART mode hides line state on data
// [R3] Charger detection works in low power mode
// [R4] Detect flag changes raise link interrupt event
// [R5] Detect flag low unless line state 00
// [R6] Link programs enables per device detect mode
// [R7] Link sets host port, no device attached
// [R8] Link adds source when host flag set
// [R9] Link keeps host charger, pulldowns for operation
// [R10] Link: line state 10 means unknown charger
// [R11] Link: line state 00/11 advances detection
// [R12] Link: clear flag means standard port
// [R13] Link: set flag means charger, advance
// [R14] Link: enhanced flag clear CDP, set DCP
// [R15] Link disables detection during USB data
// [R16] Weak pull-ups off while chip reset low
// [R17] Audio switches reset to disabled
// [R18] Audio switch follows its enable bit
// [R19] Audio switches off while chip reset low
// [R20] Single-ended receivers off in carkit mode
// [R21] Link confirms session valid before detection; the link model has no session valid input and follows its step alone
package cda_pkg;
    localparam int          REG_LEVEL_W    = 2;
    localparam logic [1:0]  LINE_SE0       = 2'h0;
    localparam logic [1:0]  REG_LEVEL_RST  = 2'h0;
    localparam logic [2:0]  AUDIO_EN_RST   = 3'h0;
    localparam int          SYNC_STAGES    = 2;
    localparam int          AUDIO_LEFT     = 0;
    localparam int          AUDIO_RIGHT    = 1;
    localparam int          AUDIO_MIC      = 2;
    typedef enum logic [2:0] {
        CDA_SYNC  = 3'b001,
        CDA_UART  = 3'b010,
        CDA_CKIT  = 3'b100
    } cda_mode_t;
endpackage

// [logic/cda_sync_if.sv]
// Interface carrying one raw bit to its synchroniser and back
`timescale 1ns/100ps
interface cda_sync_if;
    logic raw;
    logic synced;
    modport owner (output raw, input synced);
    modport stage (input raw, output synced);
endinterface

// [logic/cda_sync.sv]
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module cda_sync
    import cda_pkg::*;
(
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    cda_sync_if.stage port
);
    logic [SYNC_STAGES-1:0] chain_ff;
    logic [SYNC_STAGES-1:0] nxt_chain;
    always_comb begin
        nxt_chain = {chain_ff[SYNC_STAGES-2:0], port.raw};
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= nxt_chain;
        end
    end
    assign port.synced = chain_ff[SYNC_STAGES-1];
endmodule

// [logic/cda_ctrl.sv]
// Top of the charger detect and accessory control block
`timescale 1ns/100ps
module cda_ctrl
    import cda_pkg::*;
(
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   chip_reset_n_in,
    input  wire logic                   low_power_sel_in,
    input  wire logic                   uart_req_in,
    input  wire logic                   carkit_req_in,
    input  wire logic [REG_LEVEL_W-1:0] uart_regulator_level_in,
    input  wire logic [REG_LEVEL_W-1:0] normal_regulator_level_in,
    input  wire logic [1:0]             line_state_in,
    input  wire logic                   data_voltage_comp_in,
    input  wire logic                   data_voltage_source_en_in,
    input  wire logic                   data_current_sink_en_in,
    input  wire logic                   contact_detect_en_in,
    input  wire logic                   host_charger_en_in,
    input  wire logic                   plus_line_pulldown_in,
    input  wire logic                   minus_line_pulldown_in,
    input  wire logic                   weak_pullup_plus_en_in,
    input  wire logic                   weak_pullup_minus_en_in,
    input  wire logic                   audio_en_we_in,
    input  wire logic [2:0]             audio_en_wdata_in,
    output logic                        data_voltage_detect_out,
    output logic                        detect_change_out,
    output logic [1:0]                  line_state_out,
    output logic                        line_state_valid_out,
    output logic [REG_LEVEL_W-1:0]      regulator_level_out,
    output logic                        data_voltage_source_out,
    output logic                        data_current_sink_out,
    output logic                        contact_detect_out,
    output logic                        host_charger_out,
    output logic                        plus_pulldown_out,
    output logic                        minus_pulldown_out,
    output logic                        weak_pullup_plus_out,
    output logic                        weak_pullup_minus_out,
    output logic                        left_speaker_switch_out,
    output logic                        right_speaker_switch_out,
    output logic                        microphone_switch_out,
    output logic                        se_receiver_en_out
);
    cda_sync_if s_rst ();
    cda_sync_if s_cmp ();
    cda_sync_if s_ls0 ();
    cda_sync_if s_ls1 ();
    assign s_rst.raw = chip_reset_n_in;
    assign s_cmp.raw = data_voltage_comp_in;
    assign s_ls0.raw = line_state_in[0];
    assign s_ls1.raw = line_state_in[1];
    cda_sync u_rst (.core_clk_in(core_clk_in), .rst_in(rst_in), .port(s_rst));
    cda_sync u_cmp (.core_clk_in(core_clk_in), .rst_in(rst_in), .port(s_cmp));
    cda_sync u_ls0 (.core_clk_in(core_clk_in), .rst_in(rst_in), .port(s_ls0));
    cda_sync u_ls1 (.core_clk_in(core_clk_in), .rst_in(rst_in), .port(s_ls1));

    logic                   chip_on;
    logic [1:0]             line_now;
    assign chip_on  = s_rst.synced;
    assign line_now = {s_ls1.synced, s_ls0.synced};

    cda_mode_t              mode_ff;
    cda_mode_t              nxt_mode;
    logic [REG_LEVEL_W-1:0] level_ff;
    logic [REG_LEVEL_W-1:0] nxt_level;
    logic                   detect_ff;
    logic                   nxt_detect;
    logic                   change_ff;
    logic                   nxt_change;
    logic [1:0]             line_ff;
    logic [1:0]             nxt_line;
    logic                   line_vld_ff;
    logic                   nxt_line_vld;
    logic [2:0]             audio_en_ff;
    logic [2:0]             nxt_audio_en;
    logic [2:0]             audio_sw_ff;
    logic [2:0]             nxt_audio_sw;
    logic [5:0]             chg_ff;
    logic [5:0]             nxt_chg;
    logic [1:0]             pull_ff;
    logic [1:0]             nxt_pull;
    logic                   se_ff;
    logic                   nxt_se;

    // Mode and regulator level
    always_comb begin
        nxt_mode  = mode_ff;
        nxt_level = level_ff;
        unique case (mode_ff)
            CDA_SYNC: begin
                if (carkit_req_in) begin
                    nxt_mode = CDA_CKIT;
                end else if (uart_req_in) begin
                    nxt_mode  = CDA_UART;
                    nxt_level = uart_regulator_level_in; // [R1]
                end else begin
                    nxt_level = normal_regulator_level_in;
                end
            end
            CDA_UART: begin
                nxt_level = uart_regulator_level_in; // [R1]
                if (!uart_req_in) begin
                    nxt_mode = CDA_SYNC;
                end
            end
            CDA_CKIT: begin
                if (!carkit_req_in) begin
                    nxt_mode = CDA_SYNC;
                end
            end
            default: begin
                nxt_mode = CDA_SYNC;
            end
        endcase
    end

    // Detection path; no gating by low power select, it stays live
    always_comb begin
        nxt_detect   = s_cmp.synced && (line_now == LINE_SE0); // [R5] [R3]
        nxt_change   = nxt_detect != detect_ff; // [R4]
        // Next mode, so line state is hidden from the entry cycle on
        nxt_line     = (nxt_mode == CDA_UART) ? 2'h0 : line_now; // [R2]
        nxt_line_vld = (nxt_mode != CDA_UART); // [R2]
        nxt_chg      = {data_voltage_source_en_in, data_current_sink_en_in,
                        contact_detect_en_in, host_charger_en_in,
                        plus_line_pulldown_in, minus_line_pulldown_in};
        nxt_pull     = chip_on ? {weak_pullup_plus_en_in,
                                  weak_pullup_minus_en_in} : 2'h0; // [R16]
        nxt_se       = (nxt_mode != CDA_CKIT); // [R20]
    end

    // Audio enables and switches
    always_comb begin
        nxt_audio_en = audio_en_we_in ? audio_en_wdata_in : audio_en_ff;
        // Chip reset low drops the supply, so the switch cannot conduct
        nxt_audio_sw = chip_on ? nxt_audio_en : 3'h0; // [R18] [R19]
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_ff     <= CDA_SYNC;
            level_ff    <= REG_LEVEL_RST;
            detect_ff   <= 1'b0;
            change_ff   <= 1'b0;
            line_ff     <= 2'h0;
            line_vld_ff <= 1'b0;
            audio_en_ff <= AUDIO_EN_RST; // [R17]
            audio_sw_ff <= 3'h0; // [R17]
            chg_ff      <= 6'h0;
            pull_ff     <= 2'h0;
            se_ff       <= 1'b0;
        end else begin
            mode_ff     <= nxt_mode;
            level_ff    <= nxt_level;
            detect_ff   <= nxt_detect;
            change_ff   <= nxt_change;
            line_ff     <= nxt_line;
            line_vld_ff <= nxt_line_vld;
            audio_en_ff <= nxt_audio_en;
            audio_sw_ff <= nxt_audio_sw;
            chg_ff      <= nxt_chg;
            pull_ff     <= nxt_pull;
            se_ff       <= nxt_se;
        end
    end

    assign data_voltage_detect_out  = detect_ff;
    assign detect_change_out        = change_ff;
    assign line_state_out           = line_ff;
    assign line_state_valid_out     = line_vld_ff;
    assign regulator_level_out      = level_ff;
    assign data_voltage_source_out  = chg_ff[5];
    assign data_current_sink_out    = chg_ff[4];
    assign contact_detect_out       = chg_ff[3];
    assign host_charger_out         = chg_ff[2];
    assign plus_pulldown_out        = chg_ff[1];
    assign minus_pulldown_out       = chg_ff[0];
    assign weak_pullup_plus_out     = pull_ff[1];
    assign weak_pullup_minus_out    = pull_ff[0];
    assign left_speaker_switch_out  = audio_sw_ff[AUDIO_LEFT];
    assign right_speaker_switch_out = audio_sw_ff[AUDIO_RIGHT];
    assign microphone_switch_out    = audio_sw_ff[AUDIO_MIC];
    assign se_receiver_en_out       = se_ff;
endmodule

// [verification/cda_link_model.sv]
// Link controller model that programs the charger enables per step
`timescale 1ns/100ps
module cda_link_model
    import cda_pkg::*;
(
    input  wire logic [2:0] step_in,
    output logic      [5:0] charger_en_out
);
    // Bits: source, sink, contact, host, plus pd, minus pd
    always_comb begin
        case (step_in)
            3'h0:    charger_en_out = 6'h09;
            3'h1:    charger_en_out = 6'h30;
            3'h2:    charger_en_out = 6'h34;
            3'h4:    charger_en_out = 6'h17;
            3'h5:    charger_en_out = 6'h37;
            3'h6:    charger_en_out = 6'h07;
            default: charger_en_out = 6'h00;
        endcase
    end
endmodule

// [verification/cda_ctrl_assertions.sv]
// Checker on the top ports of the charger and accessory block
`timescale 1ns/100ps
module cda_ctrl_chk
    import cda_pkg::*;
(
    input wire logic                   core_clk_in,
    input wire logic                   rst_in,
    input wire logic                   chip_reset_n_in,
    input wire logic                   uart_req_in,
    input wire logic                   carkit_req_in,
    input wire logic [REG_LEVEL_W-1:0] uart_regulator_level_in,
    input wire logic [1:0]             line_state_in,
    input wire logic                   weak_pullup_plus_en_in,
    input wire logic                   audio_en_we_in,
    input wire logic [2:0]             audio_en_wdata_in,
    input wire logic                   data_voltage_detect_out,
    input wire logic                   detect_change_out,
    input wire logic                   line_state_valid_out,
    input wire logic [REG_LEVEL_W-1:0] regulator_level_out,
    input wire logic                   weak_pullup_plus_out,
    input wire logic                   weak_pullup_minus_out,
    input wire logic                   left_speaker_switch_out,
    input wire logic                   right_speaker_switch_out,
    input wire logic                   microphone_switch_out,
    input wire logic                   se_receiver_en_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Four samples cover the two sync stages plus the output register
    sequence s_off; !chip_reset_n_in [*4]; endsequence
    sequence s_on; chip_reset_n_in [*4]; endsequence
    sequence s_uart; uart_req_in && !carkit_req_in; endsequence
    property p_qual;
        data_voltage_detect_out |-> $past(line_state_in, 3) == LINE_SE0;
    endproperty
    a_qual: assert property (p_qual) else $error("detect outside se0");
    property p_chg;
        $changed(data_voltage_detect_out) |-> detect_change_out;
    endproperty
    a_chg: assert property (p_chg) else $error("no change event");
    property p_reg;
        s_uart |=> regulator_level_out == $past(uart_regulator_level_in);
    endproperty
    a_reg: assert property (p_reg) else $error("bad uart level");
    property p_hide; s_uart |=> !line_state_valid_out; endproperty
    a_hide: assert property (p_hide) else $error("line state shown");
    property p_pu_off;
        s_off |-> !weak_pullup_plus_out && !weak_pullup_minus_out;
    endproperty
    a_pu_off: assert property (p_pu_off) else $error("pull-up on");
    property p_pu_on;
        s_on |=> weak_pullup_plus_out == $past(weak_pullup_plus_en_in);
    endproperty
    a_pu_on: assert property (p_pu_on) else $error("pull-up stuck");
    property p_sw_off;
        s_off |-> !(left_speaker_switch_out || right_speaker_switch_out
            || microphone_switch_out);
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("switch on");
    property p_sw_on;
        s_on ##0 audio_en_we_in |=> {microphone_switch_out,
            right_speaker_switch_out, left_speaker_switch_out}
            == $past(audio_en_wdata_in);
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("switch wrong");
    property p_se; carkit_req_in |=> !se_receiver_en_out; endproperty
    a_se: assert property (p_se) else $error("receivers on");
endmodule
bind cda_ctrl cda_ctrl_chk u_chk (.core_clk_in, .rst_in, .chip_reset_n_in,
    .uart_req_in, .carkit_req_in, .uart_regulator_level_in, .line_state_in,
    .weak_pullup_plus_en_in, .audio_en_we_in, .audio_en_wdata_in,
    .data_voltage_detect_out, .detect_change_out, .line_state_valid_out,
    .regulator_level_out, .weak_pullup_plus_out, .weak_pullup_minus_out,
    .left_speaker_switch_out, .right_speaker_switch_out,
    .microphone_switch_out, .se_receiver_en_out);

// [verification/cda_ctrl_tb_top.sv]
// Testbench for the charger detect and accessory control block
`timescale 1ns/100ps
module cda_ctrl_tb_top;
    import cda_pkg::*;
    logic       core_clk_in, rst_in, chip_n, lp, uart, ckit, comp, we;
    logic       wpp, wpm, det, chg, lsv, se, l, r, m, pp, pm;
    logic [1:0] ulvl, nlvl, line, lso, rlv;
    logic [2:0] wd, step;
    logic [5:0] cen, cout;
    int         failures, n_tests;
    cda_link_model link (.step_in(step), .charger_en_out(cen));
    cda_ctrl dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .chip_reset_n_in(chip_n), .low_power_sel_in(lp), .uart_req_in(uart),
        .carkit_req_in(ckit), .uart_regulator_level_in(ulvl),
        .normal_regulator_level_in(nlvl), .line_state_in(line),
        .data_voltage_comp_in(comp), .data_voltage_source_en_in(cen[5]),
        .data_current_sink_en_in(cen[4]), .contact_detect_en_in(cen[3]),
        .host_charger_en_in(cen[2]), .plus_line_pulldown_in(cen[1]),
        .minus_line_pulldown_in(cen[0]), .weak_pullup_plus_en_in(wpp),
        .weak_pullup_minus_en_in(wpm), .audio_en_we_in(we),
        .audio_en_wdata_in(wd), .data_voltage_detect_out(det),
        .detect_change_out(chg), .line_state_out(lso),
        .line_state_valid_out(lsv), .regulator_level_out(rlv),
        .data_voltage_source_out(cout[5]), .data_current_sink_out(cout[4]),
        .contact_detect_out(cout[3]), .host_charger_out(cout[2]),
        .plus_pulldown_out(cout[1]), .minus_pulldown_out(cout[0]),
        .weak_pullup_plus_out(pp), .weak_pullup_minus_out(pm),
        .left_speaker_switch_out(l), .right_speaker_switch_out(r),
        .microphone_switch_out(m), .se_receiver_en_out(se));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step_n(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_detect;
        lp = 1'h0; line = 2'h0; comp = 1'h1; step_n(3);
        chk({det, chg}, 8'h03);
        step_n(1); chk(chg, 8'h00);
        line = 2'h2; step_n(3);
        chk({det, chg}, 8'h01);
        comp = 1'h0; step_n(1);
    endtask
    task automatic t_charger;
        for (int i = 0; i < 7; i++) begin
            step = 3'(i); step_n(1);
            chk({2'h0, cout}, {2'h0, cen});
        end
        step = 3'h3; // Detection off once data traffic runs
    endtask
    task automatic t_uart;
        ulvl = 2'h2; nlvl = 2'h1; uart = 1'h1; step_n(1);
        chk({rlv, lso, lsv, se}, 8'h21);
        uart = 1'h0; step_n(2);
    endtask
    task automatic t_chip;
        wpp = 1'h1; wpm = 1'h1; chip_n = 1'h0; we = 1'h1; wd = 3'h7;
        step_n(1); we = 1'h0; step_n(4);
        chk({l, r, m, pp, pm}, 8'h00);
        chip_n = 1'h1; step_n(4);
        chk({l, r, m, pp, pm}, 8'h1f);
        we = 1'h1; wd = 3'h2; wpp = 1'h0; step_n(1); we = 1'h0;
        chk({l, r, m, pp, pm}, 8'h09);
    endtask
    task automatic t_carkit;
        ckit = 1'h1; step_n(1); chk(se, 8'h00);
        ckit = 1'h0; step_n(2); chk(se, 8'h01);
    endtask
    initial begin
        core_clk_in = 1'h0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    initial begin
        failures = 0; n_tests = 0; rst_in = 1'h1; chip_n = 1'h1; lp = 1'h1;
        uart = 1'h0; ckit = 1'h0; comp = 1'h0; we = 1'h0; wpp = 1'h0;
        wpm = 1'h0; ulvl = 2'h0; nlvl = 2'h0; line = 2'h3; wd = 3'h0;
        step = 3'h3;
        step_n(10); rst_in = 1'h0; step_n(4);
        chk({l, r, m}, 8'h00);
        t_detect; t_charger; t_uart; t_chip; t_carkit;
        wrap_up;
    end
    initial begin
        #20000; // Tests need well under 200 cycles
        failures++;
        wrap_up;
    end
endmodule
